// ### pscfg_top.v
/*
  Power stage configuration bank: three 8-bit registers reached over
  the two-wire serial host interface, with their fields driven out to
  the analog power stage. Assumes scl/sda arrive synchronous to
  ref_clk_i and that sda is an open-drain wire resolved outside.

*/
`default_nettype none
`include "pscfg_regs.vh"

module pscfg_top (
  input  wire       ref_clk_i,
  input  wire       reset_i,
  input  wire       scl_i,                          // serial clock
  input  wire       sda_i,                          // serial data in
  output reg        sda_o,                          // serial data out
  output reg        sda_oe_o,                       // high pulls sda low
  output wire [5:0] second_overvoltage_threshold_o, // threshold code
  output wire [1:0] sync_pin_mode_o,                // sync pin function
  output wire       const_dead_time_o,              // fixed dead time
  output wire       dead_time_scaling_enable_o,     // freq scaling
  output wire [1:0] gate_min_dead_time_o,           // min dead time
  output wire [1:0] refresh_min_time_scale_o,       // on/off scale
  output wire [1:0] inductor_derating_o,            // derating
  output wire [3:0] slope_comp_sel_o                // slope select
);

  // ----------------------------------------------------------------------
  // states, one-hot
  // ----------------------------------------------------------------------
  // one bit per state keeps every state test a single-bit compare
  localparam [8:0] ST_IDLE    = 9'h001;  // waiting for start
  localparam [8:0] ST_DEVADR  = 9'h002;  // shifting device address
  localparam [8:0] ST_ACK_DEV = 9'h004;  // acking device address
  localparam [8:0] ST_PTR     = 9'h008;  // shifting register pointer
  localparam [8:0] ST_ACK_PTR = 9'h010;  // acking pointer
  localparam [8:0] ST_WDATA   = 9'h020;  // shifting write data
  localparam [8:0] ST_ACK_W   = 9'h040;  // acking write data
  localparam [8:0] ST_RDATA   = 9'h080;  // sending read data
  localparam [8:0] ST_RACK    = 9'h100;  // host ack of read byte

  // ----------------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------------
  // register index from byte address, 3 means unmapped
  function [1:0] reg_index;
    input [7:0] addr;
    begin
      case (addr)
        `PSCFG_ADDR_SECONDARY_OVERVOLTAGE_GUARD:   reg_index = 2'h0;
        `PSCFG_ADDR_TIMING: reg_index = 2'h1;
        `PSCFG_ADDR_SLOPE:  reg_index = 2'h2;
        default:            reg_index = 2'h3;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // bus line sampling
  // ----------------------------------------------------------------------
  wire [1:0] line_lvl;   // {sda, scl}
  wire [1:0] line_rise;  // rise pulses
  wire [1:0] line_fall;  // fall pulses

  pscfg_line_sampler u_sampler (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .line_i    ({sda_i, scl_i}),
    .level_o   (line_lvl),
    .rise_o    (line_rise),
    .fall_o    (line_fall)
  );

  // split the sampler vectors back into named lines
  wire scl_lvl  = line_lvl[0];
  wire sda_lvl  = line_lvl[1];
  wire scl_rise = line_rise[0];
  wire scl_fall = line_fall[0];
  // the sampler adds one clock and the engine a second one, so sda_oe_o
  // moves two clocks after the scl pin falls; each scl phase must last
  // at least four clocks for the ack and data bits to settle in time
  // an sda edge in the same clock as an scl rise is taken as data, not
  // as a start or stop, since both lines may move together
  // start and stop are sda edges while scl stays high
  wire bus_start = line_fall[1] & scl_lvl & ~line_rise[0];
  wire bus_stop  = line_rise[1] & scl_lvl & ~line_rise[0];

  // ----------------------------------------------------------------------
  // slave state
  // ----------------------------------------------------------------------
  reg  [8:0] state;       // current state
  reg  [3:0] bit_cnt;     // bits shifted in the current byte
  reg  [7:0] shreg;       // receive shift register
  reg  [7:0] txreg;       // transmit shift register
  reg  [7:0] ptr;         // register byte address
  reg        rw_read;     // transaction is a read
  reg  [7:0] stage [0:2]; // staged write data per register
  reg  [2:0] pend;        // staged byte waiting for stop
  reg  [2:0] commit;      // one-cycle load pulses to the bytes
  wire [7:0] cur [0:2];   // stored register values

  // write target decoded from the live pointer; the pointer moves only on the
  // pointer byte, the edge that stages a byte and a read ack, so the decode is never stale
  wire [1:0] wr_idx = reg_index(ptr);

  // read data for the current pointer; unmapped reads give zero
  // a pointer past the bank, or one that wrapped past 0xff, never
  // aliases onto a real register
  reg  [7:0] rd_byte;
  always @* begin
    case (reg_index(ptr))
      2'h0:    rd_byte = cur[0];
      2'h1:    rd_byte = cur[1];
      2'h2:    rd_byte = cur[2];
      default: rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------------
  // start and stop win over bit handling; a repeated start keeps
  // staged data, only a stop commits it
  // a stop in mid-byte drops the partial byte: nothing is staged until
  // all eight bits of a data byte have been shifted in
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state    <= ST_IDLE;
      bit_cnt  <= 4'h0;
      shreg    <= 8'h00;
      txreg    <= 8'h00;
      ptr      <= 8'h00;
      rw_read  <= 1'b0;
      pend     <= 3'h0;
      commit   <= 3'h0;
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
      stage[0] <= 8'h00;
      stage[1] <= 8'h00;
      stage[2] <= 8'h00;
    end else begin
      commit <= 3'h0;
      sda_o  <= 1'b0;  // open drain: only ever pulls low
      if (bus_stop) begin
        // transaction complete: apply every staged byte at once
        commit   <= pend;
        pend     <= 3'h0;
        state    <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end else if (bus_start) begin
        state    <= ST_DEVADR;
        bit_cnt  <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (scl_rise) begin
        // sample on rising clock
        case (state)
          ST_DEVADR, ST_PTR, ST_WDATA: begin
            shreg   <= {shreg[6:0], sda_lvl};
            bit_cnt <= bit_cnt + 4'h1;
          end
          ST_RACK: begin
            // a not-ack ends the read; the host then sends stop
            if (sda_lvl) begin
              state <= ST_IDLE;
            end else begin
              ptr <= ptr + 8'h01;
            end
          end
          default: begin
            state <= state;
          end
        endcase
      end else if (scl_fall) begin
        // change sda only while scl is low
        case (state)
          ST_DEVADR: begin
            if (bit_cnt == `PSCFG_BITS_PER_BYTE) begin
              if (shreg[7:1] == `PSCFG_DEV_ADDR) begin
                rw_read  <= shreg[0];
                sda_oe_o <= 1'b1;
                state    <= ST_ACK_DEV;
              end else begin
                state <= ST_IDLE;  // not ours, wait for next start
              end
            end
          end
          ST_ACK_DEV: begin
            bit_cnt <= 4'h0;
            if (rw_read) begin
              txreg    <= {rd_byte[6:0], 1'b0};
              sda_oe_o <= ~rd_byte[7];
              bit_cnt  <= 4'h1;
              state    <= ST_RDATA;
            end else begin
              sda_oe_o <= 1'b0;
              state    <= ST_PTR;
            end
          end
          ST_PTR: begin
            if (bit_cnt == `PSCFG_BITS_PER_BYTE) begin
              ptr      <= shreg;
              sda_oe_o <= 1'b1;
              state    <= ST_ACK_PTR;
            end
          end
          ST_WDATA: begin
            if (bit_cnt == `PSCFG_BITS_PER_BYTE) begin
              // unmapped addresses are acked but the data is dropped
              if (wr_idx != 2'h3) begin
                stage[wr_idx] <= shreg;
                pend[wr_idx]  <= 1'b1;
              end
              ptr      <= ptr + 8'h01;
              sda_oe_o <= 1'b1;
              state    <= ST_ACK_W;
            end
          end
          ST_ACK_PTR, ST_ACK_W: begin
            sda_oe_o <= 1'b0;
            bit_cnt  <= 4'h0;
            state    <= ST_WDATA;
          end
          ST_RDATA: begin
            if (bit_cnt == `PSCFG_BITS_PER_BYTE) begin
              sda_oe_o <= 1'b0;  // release for host ack
              state    <= ST_RACK;
            end else begin
              sda_oe_o <= ~txreg[7];
              txreg    <= {txreg[6:0], 1'b0};
              bit_cnt  <= bit_cnt + 4'h1;
            end
          end
          ST_RACK: begin
            // host acked: send the next register
            txreg    <= {rd_byte[6:0], 1'b0};
            sda_oe_o <= ~rd_byte[7];
            bit_cnt  <= 4'h1;
            state    <= ST_RDATA;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // configuration bytes
  // ----------------------------------------------------------------------
  // one instance per register; reset value and mask are fixed per
  // index, so unused bits can never be stored or read back
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_byte
      pscfg_cfg_byte #(
        .RESET_VAL ((g == 0) ? `PSCFG_RST_SECONDARY_OVERVOLTAGE_GUARD :
                    (g == 1) ? `PSCFG_RST_TIMING :
                               `PSCFG_RST_SLOPE),
        .IMPL_MASK ((g == 0) ? `PSCFG_MASK_SECONDARY_OVERVOLTAGE_GUARD :
                    (g == 1) ? `PSCFG_MASK_TIMING :
                               `PSCFG_MASK_SLOPE)
      ) u_byte (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .commit_i  (commit[g]),
        .wdata_i   (stage[g]),
        .q_o       (cur[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // field outputs to the analog power stage
  // ----------------------------------------------------------------------
  // codes pass through untouched; the analog side owns their meaning
  // each output is a slice of a stored byte, so it comes straight from
  // a flip-flop and moves only on reset or on the commit after a stop
  assign second_overvoltage_threshold_o =
    cur[0][`PSCFG_SECONDARY_OVERVOLTAGE_GUARD_THR_MSB:`PSCFG_SECONDARY_OVERVOLTAGE_GUARD_THR_LSB];
  assign sync_pin_mode_o = cur[1][`PSCFG_SYNC_MSB:`PSCFG_SYNC_LSB];
  assign const_dead_time_o = cur[1][`PSCFG_CONST_DT_BIT];
  assign dead_time_scaling_enable_o = cur[1][`PSCFG_SCALE_DT_BIT];
  assign gate_min_dead_time_o =
    cur[1][`PSCFG_MIN_DT_MSB:`PSCFG_MIN_DT_LSB];
  assign refresh_min_time_scale_o =
    cur[1][`PSCFG_REFRESH_MSB:`PSCFG_REFRESH_LSB];
  assign inductor_derating_o =
    cur[2][`PSCFG_DERATE_MSB:`PSCFG_DERATE_LSB];
  assign slope_comp_sel_o = cur[2][`PSCFG_SLOPE_MSB:`PSCFG_SLOPE_LSB];

endmodule

`default_nettype wire

// ### pscfg_regs.vh
/*
  Constants for the power stage configuration bank: register byte
  addresses, reset values, implemented-bit masks and field positions.
  Assumes it is included by bare name, from design and bench files alike.
*/
`ifndef PSCFG_REGS_VH
`define PSCFG_REGS_VH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define PSCFG_ADDR_SECONDARY_OVERVOLTAGE_GUARD      8'hd5
`define PSCFG_ADDR_TIMING    8'hd6
`define PSCFG_ADDR_SLOPE     8'hd7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PSCFG_RST_SECONDARY_OVERVOLTAGE_GUARD       8'h3f
`define PSCFG_RST_TIMING     8'h15
`define PSCFG_RST_SLOPE      8'h28

// ----------------------------------------------------------------------
// implemented bits of each register
// ----------------------------------------------------------------------
`define PSCFG_MASK_SECONDARY_OVERVOLTAGE_GUARD      8'h3f
`define PSCFG_MASK_TIMING    8'hff
`define PSCFG_MASK_SLOPE     8'h3f

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PSCFG_SECONDARY_OVERVOLTAGE_GUARD_THR_MSB   5
`define PSCFG_SECONDARY_OVERVOLTAGE_GUARD_THR_LSB   0
`define PSCFG_SYNC_MSB       7
`define PSCFG_SYNC_LSB       6
`define PSCFG_CONST_DT_BIT   5
`define PSCFG_SCALE_DT_BIT   4
`define PSCFG_MIN_DT_MSB     3
`define PSCFG_MIN_DT_LSB     2
`define PSCFG_REFRESH_MSB    1
`define PSCFG_REFRESH_LSB    0
`define PSCFG_DERATE_MSB     5
`define PSCFG_DERATE_LSB     4
`define PSCFG_SLOPE_MSB      3
`define PSCFG_SLOPE_LSB      0

// ----------------------------------------------------------------------
// serial host interface
// ----------------------------------------------------------------------
// 7-bit device address on the serial bus; the value is arbitrary
`define PSCFG_DEV_ADDR       7'h2a
`define PSCFG_BITS_PER_BYTE  4'h8

`endif

// ### pscfg_line_sampler.v
/*
  Registers the two serial host lines and produces one-cycle rise and
  fall pulses for each. Assumes the lines are already synchronous to
  ref_clk_i, so a single register stage is enough.
*/
`default_nettype none

module pscfg_line_sampler (
  input  wire       ref_clk_i,
  input  wire       reset_i,
  input  wire [1:0] line_i,      // {sda, scl}
  output reg  [1:0] level_o,     // registered level
  output reg  [1:0] rise_o,      // one-cycle pulse on 0 -> 1
  output reg  [1:0] fall_o       // one-cycle pulse on 1 -> 0
);

  // ----------------------------------------------------------------------
  // one sampler per line
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_line
      // idle bus lines are pulled high, so reset to one
      always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
          level_o[g] <= 1'b1;
          rise_o[g]  <= 1'b0;
          fall_o[g]  <= 1'b0;
        end else begin
          level_o[g] <= line_i[g];
          rise_o[g]  <= line_i[g] & ~level_o[g];
          fall_o[g]  <= ~line_i[g] & level_o[g];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ### pscfg_cfg_byte.v
/*
  One configuration byte: holds its reset value until a commit pulse
  loads new data. Bits outside the implemented mask are never stored.
  Assumes commit_i is a one-cycle pulse from the bus slave.
*/
`default_nettype none

module pscfg_cfg_byte #(
  parameter [7:0] RESET_VAL = 8'h00,  // value after reset
  parameter [7:0] IMPL_MASK = 8'hff   // implemented bits
) (
  input  wire       ref_clk_i,
  input  wire       reset_i,
  input  wire       commit_i,         // load wdata_i this cycle
  input  wire [7:0] wdata_i,          // staged write data
  output reg  [7:0] q_o               // stored value, masked
);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  // masking on the way in keeps the unused bits at zero for good
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q_o <= RESET_VAL & IMPL_MASK;
    end else if (commit_i) begin
      q_o <= wdata_i & IMPL_MASK;
    end
  end

endmodule

`default_nettype wire

// ### pscfg_properties.sv
/*
  Checker for the power stage configuration bank, bound to pscfg_top.
  Assumes scl phases of at least 4 clocks and one reset domain.
*/
`default_nettype none

module pscfg_properties (
  input wire logic       ref_clk_i,
  input wire logic       reset_i,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic [5:0] second_overvoltage_threshold_o,
  input wire logic [1:0] sync_pin_mode_o,
  input wire logic       const_dead_time_o,
  input wire logic       dead_time_scaling_enable_o,
  input wire logic [1:0] gate_min_dead_time_o,
  input wire logic [1:0] refresh_min_time_scale_o,
  input wire logic [1:0] inductor_derating_o,
  input wire logic [3:0] slope_comp_sel_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic        scl_q;      // scl one clock back
  logic        sda_q;      // sda one clock back
  logic [3:0]  since_stop; // clocks since a stop, saturates
  wire  [7:0]  tim_w = {sync_pin_mode_o, const_dead_time_o, dead_time_scaling_enable_o,
                        gate_min_dead_time_o, refresh_min_time_scale_o};
  wire  [5:0]  slo_w = {inductor_derating_o, slope_comp_sel_o};
  wire  [19:0] all_w = {second_overvoltage_threshold_o, tim_w, slo_w};
  wire         scl_fall = scl_q & ~scl_i;                // scl fell at the pins
  wire         stop_w   = scl_q & scl_i & ~sda_q & sda_i; // stop at the pins

  // saturating count, so an old stop never excuses a late change
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      since_stop <= 4'hf;
    end else begin
      scl_q      <= scl_i;
      sda_q      <= sda_i;
      since_stop <= stop_w ? 4'h0 : (since_stop == 4'hf ? 4'hf : since_stop + 4'h1);
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_start;
    scl_i && sda_i ##1 scl_i && !sda_i;
  endsequence
  sequence s_stop;
    scl_i && !sda_i ##1 scl_i && sda_i;
  endsequence

  AST_SECONDARY_OVERVOLTAGE_GUARD_RST: assert property ($fell(reset_i) |-> all_w[19:14] == 6'h3f)
    else $error("threshold not at its reset value");
  AST_TIM_RST: assert property ($fell(reset_i) |-> tim_w == 8'h15)
    else $error("timing fields not at reset value");
  AST_SLOPE_RST: assert property ($fell(reset_i) |-> slo_w == 6'h28)
    else $error("slope fields not at reset value");
  AST_COMMIT_AT_STOP: assert property (!$stable(all_w) |-> since_stop < 4'h7)
    else $error("field changed without a stop");
  AST_OE_LAG: assert property ($changed(sda_oe_o) |-> $past(scl_fall, 2))
    else $error("sda drive changed off the scl fall");
  AST_OE_STANDS: assert property ($rose(sda_oe_o) |=> sda_oe_o [*7])
    else $error("sda drive dropped too early");
  AST_START_QUIET: assert property (s_start |=> !sda_oe_o [*3])
    else $error("sda driven right after start");
  AST_STOP_QUIET: assert property (s_stop |=> !sda_oe_o [*4])
    else $error("sda driven right after stop");
endmodule

`default_nettype wire

// ### pscfg_i2c_host.sv
/*
  Host model for the two-wire bus: start, stop, byte and register tasks.
  Assumes sda_i is the resolved wire; edges are launched on ref_clk_i.
*/
`default_nettype none
`include "pscfg_regs.vh"

module pscfg_i2c_host (
  input  wire logic ref_clk_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_pull_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int nak_cnt = 0; // bytes the device left unacknowledged

  initial begin
    scl_o      = 1'b1;
    sda_pull_o = 1'b0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // one bit: sda moves a clock after scl falls, never while scl is high
  task automatic bx(input logic b, output logic r);
    @(posedge ref_clk_i) sda_pull_o <= !b;
    wait_n(4);
    scl_o <= 1'b1;
    wait_n(4);
    r = sda_i;
    scl_o <= 1'b0;
  endtask

  task automatic start();
    @(posedge ref_clk_i) sda_pull_o <= 1'b0;
    wait_n(4);
    scl_o <= 1'b1;
    wait_n(4);
    sda_pull_o <= 1'b1;
    wait_n(4);
    scl_o <= 1'b0;
  endtask

  task automatic stop();
    @(posedge ref_clk_i) sda_pull_o <= 1'b1;
    wait_n(4);
    scl_o <= 1'b1;
    wait_n(4);
    sda_pull_o <= 1'b0;
    wait_n(4);
  endtask

  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bx(d[i], r);
    bx(1'b1, r);
    ack = !r;
    if (r) nak_cnt++;
  endtask

  task automatic rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bx(1'b1, r);
      d[i] = r;
    end
    bx(last, r);
  endtask

  // byte-addressed write left open, so staging can be observed
  task automatic wr_open(input logic [7:0] a, input logic [23:0] d, input int n);
    logic k;
    start();
    tx({`PSCFG_DEV_ADDR, 1'b0}, k);
    tx(a, k);
    for (int j = 0; j < n; j++) tx(d[23-8*j -: 8], k);
  endtask

  task automatic wr(input logic [7:0] a, input logic [23:0] d, input int n);
    wr_open(a, d, n);
    stop();
  endtask

  task automatic rd(input logic [7:0] a, input int n, output logic [23:0] q);
    logic       k;
    logic [7:0] b;
    q = 24'h000000;
    start();
    tx({`PSCFG_DEV_ADDR, 1'b0}, k);
    tx(a, k);
    start();
    tx({`PSCFG_DEV_ADDR, 1'b1}, k);
    for (int j = 0; j < n; j++) begin
      rx(j == n - 1, b);
      q[23-8*j -: 8] = b;
    end
    stop();
  endtask
endmodule

`default_nettype wire

// ### tb.sv
/*
  Self-checking bench for pscfg_top, driven by the host model.
  Assumes a pulled-up sda wire shared by host and device.
*/
`default_nettype none
`include "pscfg_regs.vh"
`define CHK(g, e) chk(24'(g), 24'(e))

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i = 1'b0;
  logic        reset_i   = 1'b1;
  wire         scl_w, pull_w, sdo_w, oe_w, cdt_w, sdt_w;
  wire         sda_w = !(pull_w || oe_w); // open drain with pull-up
  wire  [5:0]  thr_w;
  wire  [1:0]  sync_w, mdt_w, ref_w, der_w;
  wire  [3:0]  slp_w;
  wire  [7:0]  tim_w = {sync_w, cdt_w, sdt_w, mdt_w, ref_w};
  wire  [5:0]  slo_w = {der_w, slp_w};
  int          errors = 0, n_tests = 0;
  logic [23:0] q;
  logic [1:0]  c;
  logic        k;

  always #20 ref_clk_i = ~ref_clk_i;

  pscfg_i2c_host i_host (.ref_clk_i(ref_clk_i), .sda_i(sda_w), .scl_o(scl_w),
                         .sda_pull_o(pull_w));
  pscfg_top i_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .scl_i(scl_w), .sda_i(sda_w),
    .sda_o(sdo_w), .sda_oe_o(oe_w), .second_overvoltage_threshold_o(thr_w),
    .sync_pin_mode_o(sync_w), .const_dead_time_o(cdt_w), .dead_time_scaling_enable_o(sdt_w),
    .gate_min_dead_time_o(mdt_w), .refresh_min_time_scale_o(ref_w),
    .inductor_derating_o(der_w), .slope_comp_sel_o(slp_w));

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    `CHK(thr_w, 6'h3f);
    `CHK(sync_w, 2'h0);
    `CHK(cdt_w, 1'b0);
    `CHK(sdt_w, 1'b1);
    `CHK(mdt_w, 2'h1);
    `CHK(ref_w, 2'h1);
    `CHK(der_w, 2'h2);
    `CHK(slp_w, 4'h8);
    `CHK(sdo_w, 1'b0);
    i_host.rd(`PSCFG_ADDR_SECONDARY_OVERVOLTAGE_GUARD, 3, q);
    `CHK(q, {`PSCFG_RST_SECONDARY_OVERVOLTAGE_GUARD, `PSCFG_RST_TIMING, `PSCFG_RST_SLOPE});
    done("reset values");
    // staged bytes stay invisible until the stop
    i_host.wr_open(`PSCFG_ADDR_SECONDARY_OVERVOLTAGE_GUARD, 24'heaffd3, 3);
    repeat (8) @(posedge ref_clk_i);
    `CHK({thr_w, tim_w, slo_w}, {6'h3f, 8'h15, 6'h28});
    i_host.stop();
    repeat (8) @(posedge ref_clk_i);
    `CHK({thr_w, tim_w, slo_w}, {6'h2a, 8'hff, 6'h13});
    i_host.rd(`PSCFG_ADDR_SECONDARY_OVERVOLTAGE_GUARD, 3, q);
    `CHK(q, 24'h2aff13);
    done("staged write");
    // every code of the two-bit fields, and both threshold extremes
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      i_host.wr(`PSCFG_ADDR_SECONDARY_OVERVOLTAGE_GUARD, {2'h3, {3{c}}, {4{c}}, 2'h3, {3{c}}}, 3);
      repeat (8) @(posedge ref_clk_i);
      `CHK(thr_w, {3{c}});
      `CHK(sync_w, c);
      `CHK({cdt_w, sdt_w}, c);
      `CHK(mdt_w, c);
      `CHK(ref_w, c);
      `CHK(der_w, c);
      `CHK(slp_w, {2{c}});
      i_host.rd(`PSCFG_ADDR_SECONDARY_OVERVOLTAGE_GUARD, 3, q);
      `CHK(q, {2'h0, {3{c}}, {4{c}}, 2'h0, {3{c}}});
    end
    done("field codes");
    i_host.wr(8'hd8, 24'h770000, 1);
    i_host.rd(8'hd8, 1, q);
    `CHK(q, 24'h000000);
    `CHK(i_host.nak_cnt, 0);
    i_host.start();
    i_host.tx(8'h20, k);
    i_host.stop();
    `CHK(k, 1'b0);
    `CHK({thr_w, tim_w, slo_w}, {6'h3f, 8'hff, 6'h3f});
    done("unmapped and foreign");
    // reset before the stop must drop the staged byte
    i_host.wr_open(`PSCFG_ADDR_TIMING, 24'h000000, 1);
    reset_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    `CHK({thr_w, tim_w, slo_w}, {6'h3f, 8'h15, 6'h28});
    // the stop after reset finds nothing staged, so the timing byte stays
    i_host.stop();
    repeat (8) @(posedge ref_clk_i);
    `CHK({thr_w, tim_w, slo_w}, {6'h3f, 8'h15, 6'h28});
    done("reset mid transfer");
    final_report();
  end

  // watchdog, far beyond the roughly 6400 clocks the tests need
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    errors++;
    $display("unexpected at %0t ns: run did not finish", $time);
    final_report();
  end
endmodule

bind pscfg_top pscfg_properties i_props (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .second_overvoltage_threshold_o(second_overvoltage_threshold_o),
  .sync_pin_mode_o(sync_pin_mode_o), .const_dead_time_o(const_dead_time_o),
  .dead_time_scaling_enable_o(dead_time_scaling_enable_o),
  .gate_min_dead_time_o(gate_min_dead_time_o),
  .refresh_min_time_scale_o(refresh_min_time_scale_o),
  .inductor_derating_o(inductor_derating_o), .slope_comp_sel_o(slope_comp_sel_o));

`default_nettype wire
